// >>> design/gisw_pkg.sv
// Package of offsets, reset values and bit positions for the interrupt source and watchdog block
package gisw_pkg;

    // Register offsets on the memory-mapped register port
    localparam logic [15:0] OFF_WD_CTL   = 16'h2178;  // Watchdog control
    localparam logic [15:0] OFF_WD_THR   = 16'h217c;  // Watchdog threshold
    localparam logic [15:0] OFF_WD_CNT   = 16'h2190;  // Watchdog live count
    localparam logic [15:0] OFF_STATUS_WRITE_MASK   = 16'h2098;  // Status write mask
    localparam logic [15:0] OFF_IDENT    = 16'h20a4;  // Interrupt identity
    localparam logic [15:0] OFF_STATUS   = 16'h20ac;  // Interrupt status
    localparam logic [15:0] OFF_ERR_ID   = 16'h20b0;  // Error identity
    localparam logic [15:0] OFF_ERR_MASK = 16'h20b4;  // Error mask

    // Reset values
    localparam logic [31:0] RST_WD_CTL   = 32'h0000_0000;
    localparam logic [31:0] RST_WD_THR   = 32'h0014_5855;
    localparam logic [31:0] RST_STATUS_WRITE_MASK   = 32'hfffe_dfff;
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;

    // Watchdog control command values
    localparam logic [31:0] WD_CMD_START = 32'h0000_0000;
    localparam logic [31:0] WD_CMD_STOP  = 32'h0000_0001;

    // Implemented interrupt bits; all others read zero and never set
    localparam logic [31:0] IMPL_MASK    = 32'h03fc_dff7;

    // Interrupt bit positions
    localparam int BIT_MEDIA_USER = 25;
    localparam int BIT_CTX_SW     = 24;
    localparam int BIT_PAGE_FAULT = 23;
    localparam int BIT_VLINE_A    = 22;  // Display B sits one below
    localparam int BIT_MEDIA_HANG = 20;
    localparam int BIT_BSP_HANG   = 19;
    localparam int BIT_FENCE      = 18;
    localparam int BIT_MASTER_ERR = 15;
    localparam int BIT_THERMAL    = 14;
    localparam int BIT_SYNC       = 12;
    localparam int BIT_FLIP_A     = 11;  // Plane B one below
    localparam int BIT_OVL_FLIP   = 9;
    localparam int BIT_FLIP_C     = 8;
    localparam int BIT_VBL_A      = 7;   // Pipe B two below
    localparam int BIT_EVT_A      = 6;   // Pipe B two below
    localparam int PIPE_STRIDE    = 2;
    localparam int BIT_DEBUG      = 2;
    localparam int BIT_USER       = 1;
    localparam int BIT_FW         = 0;

    // Structure sizes
    localparam int NUM_PIPES      = 2;
    localparam int ERR_W          = 8;
    localparam int EVT_W          = 8;

endpackage

// >>> design/gisw_watchdog.sv
// Render watchdog counter with threshold compare and wrap
`timescale 1ns/1ps
`default_nettype none
module gisw_watchdog #(
    parameter int CNT_W = 32                  // Counter and threshold width
) (
    input  wire logic             i_sys_clk,  // System clock, also the render clock
    input  wire logic             i_srst,     // Synchronous reset, active high
    input  wire logic             i_start,    // Start request, one cycle
    input  wire logic             i_stop,     // Stop and clear request, one cycle
    input  wire logic [CNT_W-1:0] i_thresh,   // Compare value
    output logic      [CNT_W-1:0] o_count,    // Live count
    output logic                  o_fire      // Threshold reached, one-cycle pulse
);
    import gisw_pkg::*;

    logic             run_r;                  // Counter running
    logic             run_nxt;
    logic [CNT_W-1:0] cnt_r;                  // Count
    logic [CNT_W-1:0] cnt_nxt;
    logic             fire_r;                 // Registered hang pulse
    logic             fire_nxt;

    // Next-state of the counter
    always_comb begin
        run_nxt  = run_r;
        cnt_nxt  = cnt_r;
        fire_nxt = 1'b0;
        if (i_stop) begin
            // Stop wins over start so a stray double write leaves it idle
            run_nxt = 1'b0;
            cnt_nxt = '0;
        end else begin
            if (i_start) begin
                run_nxt = 1'b1;
            end
            if (run_r) begin
                if (cnt_r == i_thresh) begin
                    // A zero threshold fires every cycle, hence load it first
                    fire_nxt = 1'b1;
                    cnt_nxt  = '0;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
        end
    end

    // Counter registers
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            run_r  <= 1'b0;
            cnt_r  <= '0;
            fire_r <= 1'b0;
        end else begin
            run_r  <= run_nxt;
            cnt_r  <= cnt_nxt;
            fire_r <= fire_nxt;
        end
    end

    assign o_count = cnt_r;
    assign o_fire  = fire_r;

endmodule
`default_nettype wire

// >>> design/gisw_top.sv
// Interrupt source bits, status page write trigger and render watchdog registers
`timescale 1ns/1ps
`default_nettype none
module gisw_top #(
    parameter int ERR_N = gisw_pkg::ERR_W,    // Error sources
    parameter int EVT_N = gisw_pkg::EVT_W     // Display event bits per pipe
) (
    input  wire logic                     i_sys_clk,          // System clock
    input  wire logic                     i_srst,             // Synchronous reset
    input  wire logic                     i_reg_wr,           // Register write strobe
    input  wire logic                     i_reg_rd,           // Register read strobe
    input  wire logic [15:0]              i_reg_addr,         // Register byte offset
    input  wire logic [31:0]              i_reg_wdata,        // Write data
    output logic      [31:0]              o_reg_rdata,        // Read data
    output logic                          o_reg_rvalid,       // Read data valid
    input  wire logic                     i_media_user_evt,   // Media parser user command
    input  wire logic                     i_render_user_evt,  // Render parser user command
    input  wire logic                     i_ctx_switch_evt,   // Context switch done
    input  wire logic                     i_run_list_en,      // Per-process space enable
    input  wire logic                     i_page_fault_pend,  // Translation fault pending
    input  wire logic [1:0]               i_vline_evt,        // Scan line match, [0]=A
    input  wire logic                     i_media_cnt_exceed, // Media counter overrun
    input  wire logic                     i_bsp_cnt_exceed,   // Bit stream counter overrun
    input  wire logic                     i_fence_notify,     // Fence asks for notify
    input  wire logic                     i_fence_store_done, // Fence store completed
    input  wire logic                     i_line_intr_mode,   // Line interrupts in use
    input  wire logic [ERR_N-1:0]         i_err_src,          // Error source pulses
    input  wire logic                     i_thermal_evt,      // Thermal sensor event
    input  wire logic                     i_sync_flush_done,  // Parser flush complete
    input  wire logic                     i_sync_en,          // Sync enable of parser mode
    input  wire logic                     i_engines_flushed,  // All engines flushed
    input  wire logic [2:0]               i_flip_pend,        // Plane flips, [0]=A [2]=C
    input  wire logic                     i_ovl_flip_pend,    // Overlay flip pending
    input  wire logic [1:0]               i_vblank,           // Vertical blank level, [0]=A
    input  wire logic [1:0]               i_vblank_upd_done,  // Blank updates finished
    input  wire logic [2*EVT_N-1:0]       i_disp_evt,         // Display event bits
    input  wire logic [2*EVT_N-1:0]       i_disp_evt_en,      // Display event enables
    input  wire logic                     i_eu_debug_evt,     // Kernel debug interrupt
    input  wire logic [3:0]               i_fw_byte_wr,       // Firmware register byte writes
    output logic                          o_hws_wr,           // Status page write request
    output logic      [31:0]              o_hws_data          // Status doubleword
);
    import gisw_pkg::*;

    // Register write decodes
    // Count and status offsets decode to nothing: writes there drop
    logic wr_ctl;
    logic wr_thr;
    logic wr_stam;
    logic wr_ident;
    logic wr_err_id;
    logic wr_err_mask;

    assign wr_ctl      = i_reg_wr && (i_reg_addr == OFF_WD_CTL);
    assign wr_thr      = i_reg_wr && (i_reg_addr == OFF_WD_THR);
    assign wr_stam     = i_reg_wr && (i_reg_addr == OFF_STATUS_WRITE_MASK);
    assign wr_ident    = i_reg_wr && (i_reg_addr == OFF_IDENT);
    assign wr_err_id   = i_reg_wr && (i_reg_addr == OFF_ERR_ID);
    assign wr_err_mask = i_reg_wr && (i_reg_addr == OFF_ERR_MASK);

    // Software-visible registers
    logic [31:0]      ctl_r,      ctl_nxt;       // Last control word written
    logic [31:0]      thr_r,      thr_nxt;       // Watchdog threshold
    logic [31:0]      stam_r,     stam_nxt;      // Status write mask
    logic [31:0]      ident_r,    ident_nxt;     // Sticky identity bits
    logic [31:0]      status_r,   status_nxt;    // Live status bits
    logic [ERR_N-1:0] err_id_r,   err_id_nxt;    // Sticky error identity
    logic [ERR_N-1:0] err_mask_r, err_mask_nxt;  // Error mask, one masks

    // Event sequencing state
    logic       fence_pend_r, fence_pend_nxt;    // Fence waiting on its store
    logic       sync_pend_r,  sync_pend_nxt;     // Flush waiting on engines
    logic [1:0] vbl_prev_r,   vbl_prev_nxt;      // Blank level one cycle ago
    logic [1:0] vbl_arm_r,    vbl_arm_nxt;       // Blank edge seen, updates pending
    logic [1:0] evt_prev_r,   evt_prev_nxt;      // Event OR one cycle ago

    // Output registers
    logic        hws_wr_r,  hws_wr_nxt;
    logic [31:0] hws_dat_r, hws_dat_nxt;
    logic [31:0] rdata_r,   rdata_nxt;
    logic        rvalid_r,  rvalid_nxt;

    // Watchdog connection
    logic [31:0] wd_count;
    logic        wd_fire;

    // Per-pipe vertical blank and display event detection
    // Pipe B status bits sit one stride below pipe A
    logic [1:0] vbl_fire;
    logic [1:0] vbl_arm_keep;
    logic [1:0] evt_or;
    logic [1:0] evt_rise;

    genvar p;
    generate
        for (p = 0; p < NUM_PIPES; p++) begin : g_pipe
            // Blank edge arms; the bit fires only once updates are finished
            // The arm outlives a short blank so a slow update keeps its edge
            assign vbl_fire[p]     = vbl_arm_r[p] & i_vblank_upd_done[p];
            assign vbl_arm_keep[p] = (i_vblank[p] & ~vbl_prev_r[p]) |
                                     (vbl_arm_r[p] & ~i_vblank_upd_done[p]);
            // Only enabled event bits take part in the OR
            assign evt_or[p]       = |(i_disp_evt[p*EVT_N +: EVT_N] &
                                       i_disp_evt_en[p*EVT_N +: EVT_N]);
            assign evt_rise[p]     = evt_or[p] & ~evt_prev_r[p];
        end
    endgenerate

    // Watchdog counter; control word value picks start or stop
    // Other control values are only kept for readback
    gisw_watchdog #(
        .CNT_W    (32)
    ) u_wd (
        .i_sys_clk(i_sys_clk),
        .i_srst   (i_srst),
        .i_start  (wr_ctl && (i_reg_wdata == WD_CMD_START)),
        .i_stop   (wr_ctl && (i_reg_wdata == WD_CMD_STOP)),
        .i_thresh (thr_r),
        .o_count  (wd_count),
        .o_fire   (wd_fire)
    );

    // Next values of registers, status, identity and status page write
    always_comb begin
        logic [31:0] ev;        // Status bits raised this cycle
        logic [31:0] change;    // Status bits that change state
        logic [31:0] w1c;       // Identity bits software clears
        logic        err_live;  // An unmasked error is still recorded
        ev       = '0;
        change   = '0;
        w1c      = '0;
        err_live = 1'b0;

        // Plain read/write registers
        ctl_nxt      = wr_ctl      ? i_reg_wdata : ctl_r;
        thr_nxt      = wr_thr      ? i_reg_wdata : thr_r;
        // Unimplemented mask bits are forced to one by a write
        stam_nxt     = wr_stam     ? ((i_reg_wdata & IMPL_MASK) | ~IMPL_MASK) : stam_r;
        err_mask_nxt = wr_err_mask ? i_reg_wdata[ERR_N-1:0] : err_mask_r;

        // Error identity: new errors win over the software clear
        // The next id and mask are used so a clear acts in its own cycle
        err_id_nxt = err_id_r;
        if (wr_err_id) begin
            err_id_nxt = err_id_nxt & ~i_reg_wdata[ERR_N-1:0];
        end
        err_id_nxt = err_id_nxt | i_err_src;
        err_live   = |(err_id_nxt & ~err_mask_nxt);

        // Fence waits for its store unless line interrupts are in use
        // Without the wait the host could see the notify before the data
        fence_pend_nxt = i_fence_notify |
                         (fence_pend_r & ~(i_fence_store_done | i_line_intr_mode));
        // Sync toggle waits until every engine is flushed
        sync_pend_nxt  = (i_sync_flush_done & i_sync_en) |
                         (sync_pend_r & ~i_engines_flushed);

        vbl_prev_nxt = i_vblank;
        vbl_arm_nxt  = vbl_arm_keep;
        evt_prev_nxt = evt_or;

        // Event bits are one-cycle pulses in the status word
        ev[BIT_MEDIA_USER]   = i_media_user_evt;
        ev[BIT_USER]         = i_render_user_evt;
        ev[BIT_CTX_SW]       = i_ctx_switch_evt & i_run_list_en;
        ev[BIT_VLINE_A]      = i_vline_evt[0];
        ev[BIT_VLINE_A-1]    = i_vline_evt[1];
        ev[BIT_MEDIA_HANG]   = i_media_cnt_exceed | wd_fire;
        ev[BIT_BSP_HANG]     = i_bsp_cnt_exceed;
        ev[BIT_FENCE]        = fence_pend_r &
                               (i_fence_store_done | i_line_intr_mode);
        ev[BIT_THERMAL]      = i_thermal_evt;
        ev[BIT_VBL_A]        = vbl_fire[0];
        ev[BIT_VBL_A-PIPE_STRIDE] = vbl_fire[1];
        ev[BIT_EVT_A]        = evt_rise[0];
        ev[BIT_EVT_A-PIPE_STRIDE] = evt_rise[1];
        ev[BIT_DEBUG]        = i_eu_debug_evt;
        ev[BIT_FW]           = |i_fw_byte_wr;

        // Level bits follow their sources; pulse bits follow the events
        // Plane flip and fault bits are levels: set while pending, clear after; the overlay flip bit is inside IMPL_MASK and is a level too
        status_nxt                 = ev;
        status_nxt[BIT_PAGE_FAULT] = i_page_fault_pend;
        status_nxt[BIT_MASTER_ERR] = err_live;
        status_nxt[BIT_FLIP_A]     = i_flip_pend[0];
        status_nxt[BIT_FLIP_A-1]   = i_flip_pend[1];
        status_nxt[BIT_FLIP_C]     = i_flip_pend[2];
        status_nxt[BIT_OVL_FLIP]   = i_ovl_flip_pend;
        status_nxt[BIT_SYNC]       = status_r[BIT_SYNC] ^
                                     (sync_pend_r & i_engines_flushed);
        status_nxt                 = status_nxt & IMPL_MASK;

        // Identity latches rising bits and any sync toggle
        // A set in the same cycle as a clear wins, so no event is lost
        change = (status_nxt ^ status_r) & IMPL_MASK;
        if (wr_ident) begin
            w1c = i_reg_wdata & IMPL_MASK;
            // Master error clears only once its unmasked error identity is clear
            if (err_live) begin
                w1c[BIT_MASTER_ERR] = 1'b0;
            end
        end
        ident_nxt = (ident_r & ~w1c) |
                    (change & status_nxt) |
                    (change & (32'h1 << BIT_SYNC));

        // Any change on an unmasked bit sends the whole status word
        // The word sent is the new status, so the page never lags
        hws_wr_nxt  = |(change & ~stam_r);
        hws_dat_nxt = status_nxt;

        // Read mux; unmapped offsets read zero, count ignores writes
        rvalid_nxt = i_reg_rd;
        rdata_nxt  = RST_ZERO;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                OFF_WD_CTL:   rdata_nxt = ctl_r;
                OFF_WD_THR:   rdata_nxt = thr_r;
                OFF_WD_CNT:   rdata_nxt = wd_count;
                OFF_STATUS_WRITE_MASK:   rdata_nxt = stam_r;
                OFF_IDENT:    rdata_nxt = ident_r;
                OFF_STATUS:   rdata_nxt = status_r;
                OFF_ERR_ID:   rdata_nxt = {{(32-ERR_N){1'b0}}, err_id_r};
                OFF_ERR_MASK: rdata_nxt = {{(32-ERR_N){1'b0}}, err_mask_r};
                default:      rdata_nxt = RST_ZERO;
            endcase
        end
    end

    // Register all state; every output comes from here
    // Reset is synchronous; every register runs on every edge
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ctl_r        <= RST_WD_CTL;
            thr_r        <= RST_WD_THR;
            stam_r       <= RST_STATUS_WRITE_MASK;
            ident_r      <= RST_ZERO;
            status_r     <= RST_ZERO;
            err_id_r     <= '0;
            err_mask_r   <= '0;
            fence_pend_r <= 1'b0;
            sync_pend_r  <= 1'b0;
            vbl_prev_r   <= '0;
            vbl_arm_r    <= '0;
            evt_prev_r   <= '0;
            hws_wr_r     <= 1'b0;
            hws_dat_r    <= RST_ZERO;
            rdata_r      <= RST_ZERO;
            rvalid_r     <= 1'b0;
        end else begin
            ctl_r        <= ctl_nxt;
            thr_r        <= thr_nxt;
            stam_r       <= stam_nxt;
            ident_r      <= ident_nxt;
            status_r     <= status_nxt;
            err_id_r     <= err_id_nxt;
            err_mask_r   <= err_mask_nxt;
            fence_pend_r <= fence_pend_nxt;
            sync_pend_r  <= sync_pend_nxt;
            vbl_prev_r   <= vbl_prev_nxt;
            vbl_arm_r    <= vbl_arm_nxt;
            evt_prev_r   <= evt_prev_nxt;
            hws_wr_r     <= hws_wr_nxt;
            hws_dat_r    <= hws_dat_nxt;
            rdata_r      <= rdata_nxt;
            rvalid_r     <= rvalid_nxt;
        end
    end

    assign o_reg_rdata  = rdata_r;
    assign o_reg_rvalid = rvalid_r;
    assign o_hws_wr     = hws_wr_r;
    assign o_hws_data   = hws_dat_r;

endmodule
`default_nettype wire

// >>> verification/gisw_top_asserts.sv
// Checker on the register port and the status page write port
`timescale 1ns/1ps
`default_nettype none
module gisw_top_asserts (
    input wire logic        i_sys_clk,
    input wire logic        i_srst,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [15:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic [31:0] o_reg_rdata,
    input wire logic        o_reg_rvalid,
    input wire logic        i_render_user_evt,
    input wire logic [3:0]  i_fw_byte_wr,
    input wire logic        o_hws_wr,
    input wire logic [31:0] o_hws_data
);
    import gisw_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    // Shadows of what software wrote; reserved mask bits held at one
    logic [31:0] msk_r, msk_nxt, thr_r, thr_nxt;
    logic        stp_r, stp_nxt;
    always_comb begin
        msk_nxt = (i_reg_wr && i_reg_addr == OFF_STATUS_WRITE_MASK) ? (i_reg_wdata | ~IMPL_MASK) : msk_r;
        thr_nxt = (i_reg_wr && i_reg_addr == OFF_WD_THR) ? i_reg_wdata : thr_r;
        stp_nxt = (i_reg_wr && i_reg_addr == OFF_WD_CTL && i_reg_wdata < 32'h2) ? i_reg_wdata[0] : stp_r;
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            msk_r <= RST_STATUS_WRITE_MASK | ~IMPL_MASK;
            thr_r <= RST_WD_THR;
            stp_r <= 1'b1;
        end else begin
            msk_r <= msk_nxt;
            thr_r <= thr_nxt;
            stp_r <= stp_nxt;
        end
    end
    chk_rd_answer: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    chk_thr_readback: assert property (o_reg_rvalid && $past(i_reg_rd) && !$past(i_reg_wr) &&
        $past(i_reg_addr) == OFF_WD_THR |-> o_reg_rdata == $past(thr_r)) else $error("threshold wrong");
    chk_cnt_stopped: assert property (o_reg_rvalid && $past(i_reg_rd) &&
        $past(i_reg_addr) == OFF_WD_CNT && $past(stp_r) |-> o_reg_rdata == 32'h0)
        else $error("stopped count not zero");
    chk_reserved_rd: assert property (o_reg_rvalid && ($past(i_reg_addr) == OFF_IDENT ||
        $past(i_reg_addr) == OFF_STATUS) |-> (o_reg_rdata & ~IMPL_MASK) == 32'h0)
        else $error("reserved bit read set");
    chk_reserved_hws: assert property (o_hws_wr |-> (o_hws_data & ~IMPL_MASK) == 32'h0)
        else $error("reserved bit written");
    chk_fw_hws: assert property (|i_fw_byte_wr && $past(i_fw_byte_wr) == 4'h0 && !msk_r[BIT_FW]
        |=> o_hws_wr && o_hws_data[BIT_FW]) else $error("firmware event not reported");
    chk_user_hws: assert property (i_render_user_evt && !$past(i_render_user_evt) &&
        !msk_r[BIT_USER] |=> o_hws_wr && o_hws_data[BIT_USER]) else $error("user event not reported");
    chk_hws_quiet: assert property (&msk_r && &$past(msk_r) && &$past(msk_r, 2) |-> !o_hws_wr)
        else $error("status write while all masked");
    cov_hws_user: cover property (o_hws_wr && o_hws_data[BIT_USER]);
    cov_cnt_live: cover property (o_reg_rvalid && $past(i_reg_addr) == OFF_WD_CNT && o_reg_rdata != 32'h0);
    cov_wr_rd: cover property (i_reg_wr ##2 i_reg_rd);
endmodule
bind gisw_top gisw_top_asserts u_chk (.*);
`default_nettype wire

// >>> verification/gisw_host.sv
// Host software model speaking the register strobe port
`timescale 1ns/1ps
`default_nettype none
module gisw_host (
    input  wire logic        i_sys_clk,
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_rvalid,
    output logic             o_wr,
    output logic             o_rd,
    output logic      [15:0] o_addr,
    output logic      [31:0] o_wdata
);
    import gisw_pkg::*;
    localparam logic [31:0] SW_MASKED = 32'h0358_0000;  // Sources never unmasked for status writes
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 16'h0;
        o_wdata = 32'h0;
    end
    // Released lines show the inverse so stale data is never mistaken for live
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_sys_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge i_sys_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_sys_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        @(negedge i_sys_clk);
        d = i_rvalid ? i_rdata : 32'hx;
    endtask
    task automatic set_mask(input logic [31:0] m);
        wr(OFF_STATUS_WRITE_MASK, m | SW_MASKED);
    endtask
    task automatic wd_run(input logic [31:0] t);
        wr(OFF_WD_THR, t);
        wr(OFF_WD_CTL, WD_CMD_START);
    endtask
    task automatic clr_err;
        wr(OFF_ERR_ID, 32'h0000_00ff);
        wr(OFF_IDENT, 32'h0000_8000);
    endtask
endmodule
`default_nettype wire

// >>> verification/tb_gfx_interrupt_sources_watchdog.sv
// Self-checking bench for the interrupt source and watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb_gfx_interrupt_sources_watchdog;
    import gisw_pkg::*;
    localparam byte unsigned BT [21] = '{25, 1, 24, 23, 22, 21, 20, 19, 18, 14, 12, 11, 10, 9,
                                         8, 7, 6, 5, 4, 2, 0};  // Status bit of each event
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [20:0] ev = 21'h0;   // One event source per bit
    logic        eb = 1'b0;    // Error on every source
    logic        en = 1'b0;    // Qualifying levels
    logic        hold = 1'b0;  // Completions withheld
    logic        lm = 1'b0;    // Line interrupt mode
    logic        wr, rd, hws, rvalid;
    logic [15:0] addr;
    logic [31:0] wdata, rdata, hdata, v;
    int          failures = 0, checked = 0, cycles = 0, hws_n = 0;
    initial forever #10 clk = ~clk;
    gisw_top dut (
        .i_sys_clk(clk), .i_srst(srst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_media_user_evt(ev[0]), .i_render_user_evt(ev[1]), .i_ctx_switch_evt(ev[2]),
        .i_run_list_en(en), .i_page_fault_pend(ev[3]), .i_vline_evt(ev[5:4]),
        .i_media_cnt_exceed(ev[6]), .i_bsp_cnt_exceed(ev[7]), .i_fence_notify(ev[8]),
        .i_fence_store_done(en & ~hold), .i_line_intr_mode(lm), .i_err_src({ERR_W{eb}}),
        .i_thermal_evt(ev[9]), .i_sync_flush_done(ev[10]), .i_sync_en(en),
        .i_engines_flushed(en & ~hold),
        .i_flip_pend({ev[14], ev[12], ev[11]}), .i_ovl_flip_pend(ev[13]),
        .i_vblank({ev[17], ev[15]}), .i_vblank_upd_done({2{en & ~hold}}),
        .i_disp_evt({7'h0, ev[18], 7'h0, ev[16]}), .i_disp_evt_en({16{en}}),
        .i_eu_debug_evt(ev[19]), .i_fw_byte_wr({4{ev[20]}}), .o_hws_wr(hws), .o_hws_data(hdata));
    gisw_host u_host (.i_sys_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr),
                      .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One-cycle event, then settle time for the two-stage sources
    task automatic pulse(input int k);
        @(posedge clk);
        ev <= 21'h1 << k;
        @(posedge clk);
        ev <= 21'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic results;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic t_reset;
        logic [15:0] ra [4];
        logic [31:0] rv [4];
        ra = '{OFF_WD_THR, OFF_WD_CTL, OFF_STATUS_WRITE_MASK, 16'h2000};
        rv = '{RST_WD_THR, RST_WD_CTL, RST_STATUS_WRITE_MASK, RST_ZERO};
        for (int i = 0; i < 4; i++) begin
            u_host.rd(ra[i], v);
            cmp(v, rv[i]);
        end
    endtask
    // Threshold 2 gives a period of three cycles; reads land two cycles apart
    task automatic t_wd;
        logic [31:0] c1;
        u_host.wd_run(32'h2);
        u_host.rd(OFF_WD_CNT, c1);
        u_host.rd(OFF_WD_CNT, v);
        cmp(v, (c1 + 32'h2) % 32'h3);
        u_host.rd(OFF_IDENT, v);
        cmp(v & 32'h0010_0000, 32'h0010_0000);
        u_host.wr(OFF_WD_CTL, WD_CMD_STOP);
        u_host.wr(OFF_WD_CNT, 32'h5);
        u_host.rd(OFF_WD_CNT, v);
        cmp(v, RST_ZERO);
        u_host.wr(OFF_IDENT, 32'hffff_ffff);
    endtask
    task automatic t_events;
        pulse(2);
        u_host.rd(OFF_IDENT, v);
        cmp(v, RST_ZERO);
        @(posedge clk);
        en <= 1'b1;
        for (int k = 0; k < 21; k++) begin
            pulse(k);
            u_host.rd(OFF_IDENT, v);
            cmp(v, 32'h1 << BT[k]);
            u_host.wr(OFF_IDENT, v);
        end
    endtask
    // Withheld completions hold bits back; line mode skips the store
    task automatic t_wait;
        @(posedge clk);
        hold <= 1'b1;
        pulse(8);
        pulse(10);
        pulse(15);
        u_host.rd(OFF_IDENT, v);
        cmp(v, RST_ZERO);
        @(posedge clk);
        hold <= 1'b0;
        repeat (2) @(posedge clk);
        u_host.rd(OFF_IDENT, v);
        cmp(v, 32'h0004_1080);
        u_host.wr(OFF_IDENT, v);
        @(posedge clk);
        hold <= 1'b1;
        lm <= 1'b1;
        pulse(8);
        u_host.rd(OFF_IDENT, v);
        cmp(v, 32'h0004_0000);
        u_host.wr(OFF_IDENT, v);
    endtask
    // Identity clear is refused until the error identity is cleared first
    task automatic t_err;
        @(posedge clk);
        eb <= 1'b1;
        @(posedge clk);
        eb <= 1'b0;
        u_host.rd(OFF_IDENT, v);
        cmp(v, 32'h0000_8000);
        u_host.wr(OFF_IDENT, 32'h0000_8000);
        u_host.rd(OFF_IDENT, v);
        cmp(v, 32'h0000_8000);
        u_host.clr_err();
        u_host.rd(OFF_IDENT, v);
        cmp(v, RST_ZERO);
    endtask
    // A pulse source unmasked gives a write on its rise and on its fall
    task automatic t_hws;
        u_host.set_mask(32'hffff_fffc);
        for (int k = 0; k < 2; k++) begin
            hws_n = 0;
            pulse(k == 0 ? 1 : 20);
            cmp(hws_n, 2);
        end
        u_host.set_mask(RST_STATUS_WRITE_MASK);
        u_host.wr(OFF_IDENT, 32'hffff_ffff);
    endtask
    always @(negedge clk) begin
        if (hws === 1'b1)
            hws_n++;
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_wd();
        t_events();
        t_wait();
        t_err();
        t_hws();
        results();
    end
endmodule
`default_nettype wire
